// ==== design/rcs_divider_ratio.sv ====
// rcs_divider_ratio: registered auxiliary synthesizer division ratio.
// assumes A and B are steady register values; result lags them by one cycle.
`timescale 1ns/1ns
module rcs_divider_ratio
  import rcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [9:0] auxDividerA,
  input wire logic [9:0] auxDividerB,
  output logic [DIV_RATIO_W-1:0] ratio
);

  typedef struct packed {
    logic [DIV_RATIO_W-1:0] ratio;
  } rcs_ratio_state_type;

  rcs_ratio_state_type state_q;
  rcs_ratio_state_type state_d;

  always_comb
  begin
    state_d = state_q;
    // N = B*32 + A*33
    // widen before multiplying so the product is not cut to the ten operand bits
    state_d.ratio = DIV_RATIO_W'(auxDividerB) * DIV_RATIO_W'(DIV_B_MULT)
      + DIV_RATIO_W'(auxDividerA) * DIV_RATIO_W'(DIV_A_MULT); // [RL2]
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign ratio = state_q.ratio;

  chk_ratio_follows: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(reset_n) |->
    ratio == DIV_RATIO_W'($past(auxDividerB) * 32 + $past(auxDividerA) * 33)) // [RL2]
    else $error("divider ratio does not follow A and B");

endmodule // rcs_divider_ratio

// ==== design/rcs_page_mux.sv ====
// rcs_page_mux: selects the content shown at the shared status addresses.
// assumes snapshot inputs are held by the measurement logic outside.
`timescale 1ns/1ns
module rcs_page_mux
  import rcs_pkg::*;
(
  input wire logic [3:0] signalStrengthPage,
  input wire logic [1:0] levelStatusPage,
  input wire logic [1:0] adcStatusPage,
  input wire logic [7:0] rssiLive,
  input wire logic [7:0] rssiQuiet,
  input wire logic [7:0] rssiPilot,
  input wire logic [7:0] rssiData,
  input wire logic [7:0] rssiPeak,
  input wire logic [7:0] thrTime,
  input wire logic [7:0] thrLength,
  input wire logic [7:0] errTime,
  input wire logic [31:0] levelPages,
  input wire logic [31:0] adcPages,
  output logic [7:0] view2B,
  output logic [7:0] view2C,
  output logic [7:0] view2D
);

  always_comb
  begin
    unique case (signalStrengthPage) // [RL10] [RL12]
      PG_RSSI_LIVE: view2B = rssiLive;
      PG_RSSI_QUIET: view2B = rssiQuiet; // [RL11]
      PG_RSSI_PILOT: view2B = rssiPilot;
      PG_RSSI_DATA: view2B = rssiData;
      PG_RSSI_PEAK: view2B = rssiPeak;
      PG_THR_TIME: view2B = thrTime;
      PG_THR_LENGTH: view2B = thrLength;
      PG_ERR_TIME: view2B = errTime;
      default: view2B = 8'h00;
    endcase
  end

  // pages indexed by the two-bit selectors
  assign view2C = levelPages[{levelStatusPage, 3'b000} +: 8]; // [RL9]
  assign view2D = adcPages[{adcStatusPage, 3'b000} +: 8]; // [RL8]

endmodule // rcs_page_mux

// ==== design/rcs_pkg.sv ====
// rcs_pkg: register offsets, field layouts, reset values and page codes for the
// reader configuration and status page register bank.
// assumes a byte-wide register space reached over a 32-bit classic wishbone bus.
package rcs_pkg;

  localparam int ADDR_W = 8;
  localparam int REG_W = 8;

  // register indexes as printed; byte address is four times the index
  localparam logic [7:0] IDX_AUX_DIV_A_LOW = 8'h1C;
  localparam logic [7:0] IDX_CHAN_COLL_TH = 8'h1D;
  localparam logic [7:0] IDX_MIXER_OPT = 8'h22;
  localparam logic [7:0] IDX_PAGE_SEL = 8'h29;
  localparam logic [7:0] IDX_STAT_2B = 8'h2B;
  localparam logic [7:0] IDX_STAT_2C = 8'h2C;
  localparam logic [7:0] IDX_STAT_2D = 8'h2D;
  // own registers: aux divider high bits and B value, divider ratio readback, command, mixer mode
  localparam logic [7:0] IDX_AUX_DIV_HI = 8'h40;
  localparam logic [7:0] IDX_AUX_RATIO_LO = 8'h41;
  localparam logic [7:0] IDX_AUX_RATIO_HI = 8'h42;
  localparam logic [7:0] IDX_COMMAND = 8'h43;
  localparam logic [7:0] IDX_MIXER_MODE = 8'h44;

  localparam logic [7:0] RST_AUX_DIV_A_LOW = 8'h18;
  localparam logic [7:0] RST_CHAN_COLL_TH = 8'h00;
  localparam logic [7:0] RST_MIXER_OPT = 8'h00;
  localparam logic [7:0] RST_PAGE_SEL = 8'h00;
  localparam logic [1:0] RST_AUX_A_HIGH = 2'h1;
  localparam logic [9:0] RST_AUX_B = 10'h118;

  localparam logic [7:0] CMD_STORE_RSSI = 8'hA8;

  localparam logic [5:0] DIV_B_MULT = 6'h20;
  localparam logic [5:0] DIV_A_MULT = 6'h21;

  localparam logic [3:0] PG_RSSI_LIVE = 4'h0;
  localparam logic [3:0] PG_RSSI_QUIET = 4'h2;
  localparam logic [3:0] PG_RSSI_PILOT = 4'h4;
  localparam logic [3:0] PG_RSSI_DATA = 4'h6;
  localparam logic [3:0] PG_RSSI_PEAK = 4'h8;
  localparam logic [3:0] PG_THR_TIME = 4'hC;
  localparam logic [3:0] PG_THR_LENGTH = 4'hD;
  localparam logic [3:0] PG_ERR_TIME = 4'hE;

  localparam int F_PICK_TH_LSB = 4;
  localparam int F_MIX_BIAS_LSB = 6;
  localparam int F_MIX_SINK_LSB = 3;
  localparam int F_BOOST_BIT = 0;
  localparam int F_LOWSUP_BIT = 1;
  localparam int F_ADC_PG_LSB = 6;
  localparam int F_LVL_PG_LSB = 4;

  localparam int DIV_RATIO_W = 16;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } rcs_bus_type;

endpackage

// ==== design/rcs_reader_config_status_page_regs.sv ====
// rcs_reader_config_status_page_regs: configuration and status page register bank.
// assumes a classic wishbone master on ref_clk; status snapshots come from outside.
//
// Contract
// [RL1] aux divider A low byte stored at 1Ch, joined with two high bits.
// [RL2] aux ratio equals B times 32 plus A times 33.
// [RL3] RSSI counts for I/Q selection only above bits 7:4 of 1Dh.
// [RL4] bits 3:0 of 1Dh are the collision RSSI threshold.
// [RL5] bits 5:3 of 22h select mixer load stage current.
// [RL6] single-ended mixer: bits 2:0 form the input voltage range.
// [RL7] differential mixer: bit2 reserved, bit1 low supply, bit0 range boost.
// [RL8] page bits 7:6 choose what 2Dh returns.
// [RL9] page bits 5:4 choose what 2Ch returns.
// [RL10] codes 0000 live, 0100 pilot, 0110 data, 1000 peak at 2Bh.
// [RL11] code 0010 shows quiet RSSI captured only by command A8h.
// [RL12] codes 1100, 1101, 1110 show timing values in received bits.
// [RL13] page writes change only read content, never measurement state.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ns
module rcs_reader_config_status_page_regs
  import rcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [7:0] rssiLive,
  input wire logic [7:0] rssiPilot,
  input wire logic [7:0] rssiData,
  input wire logic [7:0] rssiPeak,
  input wire logic [7:0] thrTime,
  input wire logic [7:0] thrLength,
  input wire logic [7:0] errTime,
  input wire logic [31:0] levelPages,
  input wire logic [31:0] adcPages,
  input wire logic singleEndedMixer,
  output logic [9:0] auxDividerA,
  output logic [9:0] auxDividerB,
  output logic [DIV_RATIO_W-1:0] auxDividerRatio,
  output logic [3:0] channelPickThreshold,
  output logic [3:0] collisionRssiThreshold,
  output logic iqRssiQualifies,
  output logic [1:0] mixerBiasTrim,
  output logic [2:0] mixerSinkCurrent,
  output logic [2:0] mixerVoltageRange,
  output logic lowSupplyBias,
  output logic mixerRangeBoost
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    rcs_bus_type bus;
    logic [31:0] rdData;
    logic err;
    logic [7:0] auxALow;
    logic [1:0] auxAHigh;
    logic [9:0] auxB;
    logic [7:0] thresholds;
    logic [7:0] mixerOpt;
    logic [7:0] pageSel;
    logic [7:0] rssiQuiet;
    logic mixerModeSingle;
  } rcs_regs_state_type;

  rcs_regs_state_type state_q;
  rcs_regs_state_type state_d;

  logic [7:0] view2B;
  logic [7:0] view2C;
  logic [7:0] view2D;
  logic [7:0] regIndex;
  logic busReq;
  logic wrLane0;

  function automatic logic [7:0] nib_hi(input logic [7:0] v);
    return {4'h0, v[7:4]};
  endfunction

  assign regIndex = wb_adr_i[9:2];
  assign busReq = wb_cyc_i && wb_stb_i && (state_q.bus == BUS_IDLE);
  assign wrLane0 = busReq && wb_we_i && wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // register access

  always_comb
  begin
    logic known;
    logic [7:0] rd;
    known = 1'b1;
    rd = 8'h00;
    state_d = state_q;
    unique case (regIndex)
      IDX_AUX_DIV_A_LOW: rd = state_q.auxALow; // [RL1]
      IDX_CHAN_COLL_TH: rd = state_q.thresholds;
      IDX_MIXER_OPT: rd = state_q.mixerOpt;
      IDX_PAGE_SEL: rd = state_q.pageSel;
      IDX_STAT_2B: rd = view2B;
      IDX_STAT_2C: rd = view2C;
      IDX_STAT_2D: rd = view2D;
      IDX_AUX_DIV_HI: rd = {state_q.auxB[9:6], 2'b00, state_q.auxAHigh};
      IDX_AUX_RATIO_LO: rd = auxDividerRatio[7:0];
      IDX_AUX_RATIO_HI: rd = auxDividerRatio[15:8];
      IDX_COMMAND: rd = 8'h00;
      IDX_MIXER_MODE: rd = {7'h00, state_q.mixerModeSingle};
      default: known = 1'b0;
    endcase
    unique case (state_q.bus)
      BUS_IDLE:
      begin
        if (busReq)
        begin
          state_d.bus = BUS_ACK;
          state_d.err = !known;
          state_d.rdData = {24'h000000, rd};
        end
      end
      BUS_ACK:
      begin
        state_d.bus = BUS_IDLE;
        state_d.err = 1'b0;
      end
    endcase
    if (wrLane0)
    begin
      unique case (regIndex)
        IDX_AUX_DIV_A_LOW: state_d.auxALow = wb_dat_i[7:0]; // [RL1]
        IDX_CHAN_COLL_TH: state_d.thresholds = wb_dat_i[7:0]; // [RL3] [RL4]
        IDX_MIXER_OPT: state_d.mixerOpt = wb_dat_i[7:0]; // [RL5]
        IDX_PAGE_SEL: state_d.pageSel = wb_dat_i[7:0]; // [RL13]
        IDX_AUX_DIV_HI:
        begin
          state_d.auxAHigh = wb_dat_i[1:0];
          state_d.auxB[9:6] = wb_dat_i[7:4];
        end
        IDX_COMMAND:
        begin
          // quiet level is only ever captured here
          if (wb_dat_i[7:0] == CMD_STORE_RSSI)
            state_d.rssiQuiet = rssiLive; // [RL11]
        end
        IDX_MIXER_MODE: state_d.mixerModeSingle = wb_dat_i[0];
        default: state_d.auxB = state_q.auxB;
      endcase
    end
    if (wrLane0 && wb_sel_i[1] && regIndex == IDX_AUX_DIV_HI)
      state_d.auxB[5:0] = wb_dat_i[13:8];
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= '0;
      state_q.bus <= BUS_IDLE;
      state_q.auxALow <= RST_AUX_DIV_A_LOW;
      state_q.auxAHigh <= RST_AUX_A_HIGH;
      state_q.auxB <= RST_AUX_B;
      state_q.thresholds <= RST_CHAN_COLL_TH;
      state_q.mixerOpt <= RST_MIXER_OPT;
      state_q.pageSel <= RST_PAGE_SEL;
    end
    else
      state_q <= state_d;
  end

  assign wb_ack_o = (state_q.bus == BUS_ACK) && !state_q.err;
  assign wb_err_o = (state_q.bus == BUS_ACK) && state_q.err;
  assign wb_dat_o = state_q.rdData;

  ////////////////////////////////////////////////////////////////////////////
  // decoded fields

  assign auxDividerA = {state_q.auxAHigh, state_q.auxALow}; // [RL1]
  assign auxDividerB = state_q.auxB;
  assign channelPickThreshold = state_q.thresholds[F_PICK_TH_LSB +: 4]; // [RL3]
  assign collisionRssiThreshold = state_q.thresholds[3:0]; // [RL4]
  // I is the low nibble of the live RSSI, Q the high one
  assign iqRssiQualifies = (rssiLive[3:0] > channelPickThreshold)
    || (nib_hi(rssiLive) > {4'h0, channelPickThreshold}); // [RL3]
  assign mixerBiasTrim = state_q.mixerOpt[F_MIX_BIAS_LSB +: 2];
  assign mixerSinkCurrent = state_q.mixerOpt[F_MIX_SINK_LSB +: 3]; // [RL5]
  // the same three bits mean different things depending on the mixer in use
  assign mixerVoltageRange = singleEndedMixer ? state_q.mixerOpt[2:0] : 3'h0; // [RL6]
  assign lowSupplyBias = !singleEndedMixer && state_q.mixerOpt[F_LOWSUP_BIT]; // [RL7]
  assign mixerRangeBoost = !singleEndedMixer && state_q.mixerOpt[F_BOOST_BIT]; // [RL7]

  ////////////////////////////////////////////////////////////////////////////
  // submodules

  rcs_divider_ratio u_ratio (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .auxDividerA(auxDividerA),
    .auxDividerB(auxDividerB),
    .ratio(auxDividerRatio)
  );

  rcs_page_mux u_pages (
    .signalStrengthPage(state_q.pageSel[3:0]),
    .levelStatusPage(state_q.pageSel[F_LVL_PG_LSB +: 2]),
    .adcStatusPage(state_q.pageSel[F_ADC_PG_LSB +: 2]),
    .rssiLive(rssiLive),
    .rssiQuiet(state_q.rssiQuiet),
    .rssiPilot(rssiPilot),
    .rssiData(rssiData),
    .rssiPeak(rssiPeak),
    .thrTime(thrTime),
    .thrLength(thrLength),
    .errTime(errTime),
    .levelPages(levelPages),
    .adcPages(adcPages),
    .view2B(view2B),
    .view2C(view2C),
    .view2D(view2D)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_write(logic [7:0] idx);
    wrLane0 && regIndex == idx;
  endsequence

  chk_a_low_store: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_write(IDX_AUX_DIV_A_LOW) |=> auxDividerA[7:0] == $past(wb_dat_i[7:0])) // [RL1]
    else $error("divider A low byte not stored");

  chk_ratio_value: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $stable(auxDividerA) && $stable(auxDividerB) |=>
    auxDividerRatio == 16'($past(auxDividerB) * 32 + $past(auxDividerA) * 33)) // [RL2]
    else $error("divider ratio wrong");

  chk_pick_qualify: assert property (@(posedge ref_clk) disable iff (!reset_n)
    iqRssiQualifies == (rssiLive[3:0] > state_q.thresholds[7:4]
    || rssiLive[7:4] > state_q.thresholds[7:4])) // [RL3]
    else $error("channel pick qualification wrong");

  chk_coll_thresh: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_write(IDX_CHAN_COLL_TH) |=> collisionRssiThreshold == $past(wb_dat_i[3:0])) // [RL4]
    else $error("collision threshold not stored");

  chk_sink_current: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_write(IDX_MIXER_OPT) |=> mixerSinkCurrent == $past(wb_dat_i[5:3])) // [RL5]
    else $error("sink current field wrong");

  chk_single_range: assert property (@(posedge ref_clk) disable iff (!reset_n)
    singleEndedMixer |-> mixerVoltageRange == state_q.mixerOpt[2:0]
    && !lowSupplyBias && !mixerRangeBoost) // [RL6]
    else $error("single ended range wrong");

  chk_diff_bits: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !singleEndedMixer |-> mixerRangeBoost == state_q.mixerOpt[0]
    && lowSupplyBias == state_q.mixerOpt[1]) // [RL7]
    else $error("differential mixer bits wrong");

  chk_page_2d: assert property (@(posedge ref_clk) disable iff (!reset_n)
    view2D == adcPages[8 * state_q.pageSel[7:6] +: 8]) // [RL8]
    else $error("2Dh page wrong");

  chk_page_2c: assert property (@(posedge ref_clk) disable iff (!reset_n)
    view2C == levelPages[8 * state_q.pageSel[5:4] +: 8]) // [RL9]
    else $error("2Ch page wrong");

  chk_page_peak: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_q.pageSel[3:0] == 4'h8 |-> view2B == rssiPeak) // [RL10]
    else $error("peak page wrong");

  chk_quiet_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !s_write(IDX_COMMAND) |=> $stable(state_q.rssiQuiet)) // [RL11]
    else $error("quiet level changed without command");

  chk_err_time: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_q.pageSel[3:0] == 4'hE |-> view2B == errTime) // [RL12]
    else $error("error time page wrong");

  chk_page_no_side: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_write(IDX_PAGE_SEL) |=> $stable(state_q.thresholds) && $stable(state_q.mixerOpt)
    && $stable(state_q.rssiQuiet)) // [RL13]
    else $error("page write disturbed state");

endmodule // rcs_reader_config_status_page_regs

// ==== testbench/rcs_reader_config_status_page_regs_test.sv ====
// rcs_reader_config_status_page_regs_test: self-checking bench for the register bank.
// assumes one ack or err pulse per classic wishbone request; drives all inputs itself.
`timescale 1ns/1ns
module rcs_reader_config_status_page_regs_test
  import rcs_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [9:0] wbAdr = '0;
  logic [3:0] wbSel = '0;
  logic [31:0] wbDatI = '0, wbDatO, levelPages = '0, adcPages = '0, rd;
  logic wbAck, wbErr, er, iqRssiQualifies, lowSupplyBias, mixerRangeBoost;
  logic singleEndedMixer = 1'b0;
  logic [7:0] rssiLive = '0, rssiPilot = '0, rssiData = '0, rssiPeak = '0;
  logic [7:0] thrTime = '0, thrLength = '0, errTime = '0, quietExp = '0, v;
  logic [9:0] auxDividerA, auxDividerB, aExp, bExp;
  logic [15:0] auxDividerRatio;
  logic [3:0] channelPickThreshold, collisionRssiThreshold;
  logic [1:0] mixerBiasTrim;
  logic [2:0] mixerSinkCurrent, mixerVoltageRange;
  int failCount = 0, totalChecks = 0, seed = 32'hDF43;

  rcs_reader_config_status_page_regs u_rcs_reader_config_status_page_regs (
    .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .wb_err_o(wbErr), .rssiLive(rssiLive),
    .rssiPilot(rssiPilot), .rssiData(rssiData), .rssiPeak(rssiPeak), .thrTime(thrTime),
    .thrLength(thrLength), .errTime(errTime), .levelPages(levelPages), .adcPages(adcPages),
    .singleEndedMixer(singleEndedMixer), .auxDividerA(auxDividerA),
    .auxDividerB(auxDividerB), .auxDividerRatio(auxDividerRatio),
    .channelPickThreshold(channelPickThreshold),
    .collisionRssiThreshold(collisionRssiThreshold), .iqRssiQualifies(iqRssiQualifies),
    .mixerBiasTrim(mixerBiasTrim), .mixerSinkCurrent(mixerSinkCurrent),
    .mixerVoltageRange(mixerVoltageRange), .lowSupplyBias(lowSupplyBias),
    .mixerRangeBoost(mixerRangeBoost)
  );

  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic checkVal(input logic [15:0] got, input logic [15:0] exp, input string what);
    totalChecks++;
    if (got !== exp)
    begin
      failCount++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic checkFlag(input logic got, input logic exp, input string what);
    totalChecks++;
    if (got !== exp)
    begin
      failCount++;
      $display("ERROR %0t %s flag %b exp %b", $time, what, got, exp);
    end
  endtask

  // values sampled right after the edge are the pre-edge ones, so ack is seen as sampled
  task automatic wbXfer(input logic [7:0] idx, input logic we, input logic [31:0] d,
                        input logic [3:0] sel);
    int n;
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbSel <= sel;
    wbDatI <= d;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 16);
    rd = wbDatO;
    er = wbErr;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    if (wbAck !== 1'b1 && wbErr !== 1'b1)
    begin
      failCount++;
      $display("ERROR %0t bus answer timed out", $time);
      test_done();
    end
  endtask

  task automatic regWrite(input logic [7:0] idx, input logic [7:0] d);
    wbXfer(idx, 1'b1, {24'h0, d}, 4'h1);
  endtask

  task automatic regRead(input logic [7:0] idx, input logic [7:0] exp, input string what);
    wbXfer(idx, 1'b0, 32'h0, 4'hF);
    checkFlag(er, 1'b0, what);
    checkVal(rd[15:0], {8'h00, exp}, what);
  endtask

  function automatic logic [7:0] pageByte(input logic [3:0] c);
    case (c)
      4'h0: return rssiLive;
      4'h2: return quietExp;
      4'h4: return rssiPilot;
      4'h6: return rssiData;
      4'h8: return rssiPeak;
      4'hC: return thrTime;
      4'hD: return thrLength;
      4'hE: return errTime;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [15:0] ratioExp();
    return {6'h0, bExp} * 16'h20 + {6'h0, aExp} * 16'h21;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (50000) @(posedge ref_clk);
    failCount++;
    $display("ERROR %0t run limit reached", $time);
    test_done();
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    regRead(IDX_AUX_DIV_A_LOW, 8'h18, "a low reset");
    regRead(IDX_CHAN_COLL_TH, 8'h00, "thr reset");
    regRead(IDX_MIXER_OPT, 8'h00, "mixer reset");
    regRead(IDX_PAGE_SEL, 8'h00, "page reset");
    aExp = 10'h118;
    bExp = 10'h118;
    checkVal({6'h0, auxDividerA}, {6'h0, aExp}, "a reset");
    checkVal(auxDividerRatio, ratioExp(), "ratio reset");
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      aExp = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'($random(seed) & 32'h1FF);
      bExp = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($random(seed) & 32'h1FF);
      wbXfer(IDX_AUX_DIV_HI, 1'b1, {18'h0, bExp[5:0], bExp[9:6], 2'b00, aExp[9:8]}, 4'h3);
      regWrite(IDX_AUX_DIV_A_LOW, aExp[7:0]);
      // lane 0 disabled: the stored byte must survive
      wbXfer(IDX_AUX_DIV_A_LOW, 1'b1, {24'h0, ~aExp[7:0]}, 4'h0);
      regRead(IDX_AUX_DIV_A_LOW, aExp[7:0], "a low");
      repeat (2) @(posedge ref_clk);
      checkVal({6'h0, auxDividerA}, {6'h0, aExp}, "a joined");
      checkVal(auxDividerRatio, ratioExp(), "ratio");
      regRead(IDX_AUX_RATIO_LO, 8'(ratioExp()), "ratio lo");
      regRead(IDX_AUX_RATIO_HI, 8'(ratioExp() >> 8), "ratio hi");
    end
    $display("test divider done");
    for (int i = 0; i < 8; i++)
    begin
      v = (i < 2) ? 8'h5A : 8'($random(seed));
      regWrite(IDX_CHAN_COLL_TH, v);
      rssiLive <= (i == 0) ? 8'h55 : (i == 1) ? 8'h56 : 8'($random(seed));
      repeat (2) @(posedge ref_clk);
      checkVal(16'(channelPickThreshold), 16'(v[7:4]), "pick thr");
      checkVal(16'(collisionRssiThreshold), 16'(v[3:0]), "coll thr");
      checkFlag(iqRssiQualifies, rssiLive[7:4] > v[7:4] || rssiLive[3:0] > v[7:4], "iq");
    end
    $display("test thresholds done");
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($random(seed));
      regWrite(IDX_MIXER_OPT, v);
      singleEndedMixer <= i[0];
      repeat (2) @(posedge ref_clk);
      checkVal(16'(mixerSinkCurrent), 16'(v[5:3]), "sink");
      checkVal(16'(mixerBiasTrim), 16'(v[7:6]), "bias trim");
      checkVal(16'(mixerVoltageRange), i[0] ? 16'(v[2:0]) : 16'h0, "range");
      checkFlag(lowSupplyBias, !i[0] && v[1], "low supply");
      checkFlag(mixerRangeBoost, !i[0] && v[0], "boost");
      regRead(IDX_MIXER_OPT, v, "mixer rd");
    end
    $display("test mixer done");
    {rssiPilot, rssiData, rssiPeak, thrTime} <= 32'($random(seed));
    {thrLength, errTime, rssiLive} <= 24'($random(seed));
    levelPages <= 32'($random(seed));
    adcPages <= 32'($random(seed));
    for (int p = 0; p < 2; p++)
    begin
      if (p == 1)
      begin
        regWrite(IDX_COMMAND, CMD_STORE_RSSI);
        quietExp = rssiLive;
        rssiLive <= ~rssiLive;
      end
      else
        regWrite(IDX_COMMAND, 8'h00);
      for (int c = 0; c < 16; c++)
      begin
        regWrite(IDX_PAGE_SEL, {c[3:2], c[1:0], c[3:0]});
        regRead(IDX_PAGE_SEL, {c[3:2], c[1:0], c[3:0]}, "page rd");
        regRead(IDX_STAT_2B, pageByte(c[3:0]), "view 2b");
        regRead(IDX_STAT_2C, levelPages[8 * c[1:0] +: 8], "view 2c");
        regRead(IDX_STAT_2D, adcPages[8 * c[3:2] +: 8], "view 2d");
      end
    end
    regRead(IDX_MIXER_OPT, v, "mixer kept");
    checkVal(auxDividerRatio, ratioExp(), "ratio kept");
    $display("test pages done");
    wbXfer(8'h00, 1'b0, 32'h0, 4'hF);
    checkFlag(er, 1'b1, "unmapped read err");
    wbXfer(8'h3F, 1'b1, 32'hFF, 4'h1);
    checkFlag(er, 1'b1, "unmapped write err");
    $display("test unmapped done");
    test_done();
  end
endmodule // rcs_reader_config_status_page_regs_test
